// File: sim/drive_trip_code_and_profile_regs_tb_top.sv
`timescale 1ns/100ps
`include "drt_cfg.svh"

module drive_trip_code_and_profile_regs_tb_top;
   logic clk_i;
   logic nrst_i;
   logic [15:0] addr, wdata, rdata, ftgt, tword;
   logic wr, rd, tval, fnet, irq, rd_seen;
   drt_pkg::drt_trip_e tcls;
   logic [3:0] tidx, tstat;
   logic [7:0] fsel;
   logic [1:0] msel;
   logic [18:0] acc, dec;
   logic [15:0] exp_q[$];
   int err_total;
   int n_compared;

   ////////////////////////////////////////////////////////////////////////////
   // Clock of 40 ns period.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   drt_net_master u_nm (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

   drt_regbank u_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .trip_class_i(tcls), .trip_index_i(tidx), .drive_status_i(tstat),
      .trip_valid_i(tval), .freq_src_sel_i(fsel), .motor_sel_i(msel), .freq_target_o(ftgt),
      .freq_from_net_o(fnet), .accel_time_o(acc), .decel_time_o(dec), .trip_word_o(tword),
      .irq_o(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // The answer is read one cycle after the strobe, so the note is queued first.
   task automatic rd_exp(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_nm.rd_word(a);
   endtask : rd_exp

   task automatic settle();
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask : settle

   task automatic trip(input int c, input int i, input logic [3:0] s);
      @(posedge clk_i);
      tcls <= drt_pkg::drt_trip_e'(c);
      tidx <= 4'(i);
      tstat <= s;
      tval <= 1'b1;
      @(posedge clk_i);
      tval <= 1'b0;
      @(negedge clk_i);
   endtask : trip

   // Cause code expected for each fault class and sub-index.
   function automatic logic [7:0] code_of(input int c, input int i);
      logic [7:0] hw [8] = '{8'h17, 8'h18, 8'h19, 8'h1e, 8'h23, 8'h24, 8'h25, 8'h26};
      case (c)
         5: return 8'h05 + 8'(i);
         6: return 8'h14;
         7: return 8'h15;
         8: return hw[i];
         9: return 8'h2b;
         10: return 8'h2c;
         11: return 8'h2d;
         12: return 8'h32 + 8'(i);
         13: return 8'h3c + 8'(i);
         14: return 8'h46 + 8'(i);
         default: return 8'(c);
      endcase
   endfunction : code_of

   function automatic int nidx(input int c);
      return (c == 5) ? 12 : (c == 8) ? 8 : (c >= 12) ? 10 : 1;
   endfunction : nidx

   ////////////////////////////////////////////////////////////////////////////
   // Read monitor: the cycle after each strobe takes the oldest note.
   always @(posedge clk_i) begin
      if (rd_seen === 1'b1 && exp_q.size() > 0) begin
         chk(rdata, exp_q.pop_front(), "read data");
      end
      rd_seen <= rd;
   end

   // Watchdog sized well above the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      end_of_test();
   end

   // Main sequence.
   initial begin
      logic [3:0] s;
      logic [15:0] a, ew;
      logic [31:0] v, w;
      void'($urandom(41796));
      nrst_i = 1'b0;
      tcls = drt_pkg::DRT_TC_NONE;
      tidx = 4'h0;
      tstat = 4'h0;
      tval = 1'b0;
      fsel = 8'h00;
      msel = 2'h0;
      rd_seen = 1'b0;
      err_total = 0;
      n_compared = 0;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(negedge clk_i);
      chk(ftgt, 32'h0000_0000, "freq reset");
      chk(acc, 32'h0000_0bb8, "accel reset");
      chk(tword, 32'h0000_0000, "trip reset");
      rd_exp(`DRT_A_DEC1_L, 16'h0bb8);
      $display("test reset done");
      // Every class and sub-index, with a random status of 0 to 9.
      u_nm.wr_word(`DRT_A_IRQ_EN, 16'h0001);
      for (int c = 0; c < 15; c++) begin
         for (int i = 0; i < nidx(c); i++) begin
            s = 4'($urandom_range(9));
            trip(c, i, s);
            ew = {code_of(c, i), 4'h0, s};
            chk(tword, ew, "trip word");
         end
      end
      @(negedge clk_i);
      chk(irq, 32'h1, "irq on trip");
      // Illegal sub-index and status are dropped without an event.
      u_nm.wr_word(`DRT_A_IRQ_CLR, 16'h0003);
      trip(13, 10, 4'h3);
      trip(14, 0, 4'ha);
      settle();
      chk(tword, ew, "bad trip");
      chk(irq, 32'h0, "irq cleared");
      rd_exp(`DRT_A_IRQ_STS, 16'h0000);
      u_nm.wr_word(`DRT_A_IRQ_EN, 16'h0000);
      trip(1, 0, 4'h3);
      settle();
      chk(irq, 32'h0, "irq masked");
      rd_exp(`DRT_A_TRIP, 16'h0103);
      rd_exp(`DRT_A_IRQ_STS, 16'h0001);
      u_nm.wr_word(`DRT_A_IRQ_EN, 16'h0003);
      settle();
      chk(irq, 32'h1, "irq unmasked");
      rd_exp(`DRT_A_IRQ_EN, 16'h0003);
      u_nm.wr_word(`DRT_A_IRQ_CLR, 16'h0003);
      $display("test trip done");
      // Frequency target and its range limit.
      @(posedge clk_i);
      fsel <= 8'h03;
      u_nm.wr_pair(`DRT_A_FREQ_H, 32'h0000_9c40);
      settle();
      chk(ftgt, 32'h0000_9c40, "freq max");
      chk(fnet, 32'h1, "net source");
      u_nm.wr_pair(`DRT_A_FREQ_H, 32'h0000_9c41);
      @(posedge clk_i);
      fsel <= 8'h02;
      settle();
      chk(ftgt, 32'h0000_9c40, "freq over");
      chk(fnet, 32'h0, "other source");
      chk(irq, 32'h1, "irq range");
      rd_exp(`DRT_A_FREQ_L, 16'h9c40);
      rd_exp(`DRT_A_IRQ_STS, 16'h0002);
      v = 32'($urandom_range(40000));
      u_nm.wr_pair(`DRT_A_FREQ_H, v);
      settle();
      chk(ftgt, v, "freq random");
      $display("test frequency done");
      // Times of all three motors, short and long enough to be truncated.
      for (int m = 0; m < 3; m++) begin
         a = 16'h1103 + 16'(m) * 16'h1000;
         v = 32'($urandom_range(9999, 1));
         w = 32'($urandom_range(360000, 10000));
         u_nm.wr_pair(a, v);
         u_nm.wr_pair(a + 16'h0002, w);
         @(posedge clk_i);
         msel <= 2'(m);
         settle();
         chk(acc, v, "accel");
         chk(dec, w - w % 10, "decel");
         rd_exp(a + 16'h0003, w[15:0]);
      end
      // Limits on motor one, seen through the spare select code.
      @(posedge clk_i);
      msel <= 2'h3;
      u_nm.wr_pair(`DRT_A_ACC1_H, 32'h0005_7e40);
      u_nm.wr_pair(`DRT_A_DEC1_H, 32'h0000_2719);
      settle();
      chk(acc, 32'h0005_7e40, "accel max");
      chk(dec, 32'h0000_2710, "decel trunc");
      u_nm.wr_pair(`DRT_A_ACC1_H, 32'h0005_7e41);
      u_nm.wr_pair(`DRT_A_ACC1_H, 32'h0000_0000);
      settle();
      chk(acc, 32'h0005_7e40, "accel refused");
      u_nm.wr_word(16'h1107, 16'hffff);
      rd_exp(16'h1107, 16'h0000);
      settle();
      $display("test times done");
      chk(32'(exp_q.size()), 32'h0, "reads left");
      end_of_test();
   end
endmodule : drive_trip_code_and_profile_regs_tb_top

// File: sim/drt_net_master.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Serial network master: one-cycle word writes and reads on the holding port.
module drt_net_master (
   input wire logic clk_i,
   output logic [15:0] addr_o,
   output logic [15:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // Idle bus at time zero.
   initial begin
      addr_o = 16'hffff;
      wdata_o = 16'h5a5a;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // Address and data are inverted on release so stale values never look valid.
   task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : wr_word

   // A read holds the address for its one strobe cycle only.
   task automatic rd_word(input logic [15:0] a);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
   endtask : rd_word

   // High word goes first at the lower address; the low word commits the pair.
   task automatic wr_pair(input logic [15:0] a_hi, input logic [31:0] v);
      wr_word(a_hi, v[31:16]);
      wr_word(a_hi + 16'h0001, v[15:0]);
   endtask : wr_pair
endmodule : drt_net_master

// File: verilog/drt_cfg.svh
`ifndef DRT_CFG_SVH
`define DRT_CFG_SVH

// Holding register word addresses of the profile parameter pairs.
`define DRT_A_FREQ_H 16'h0001
`define DRT_A_FREQ_L 16'h0002
`define DRT_A_ACC1_H 16'h1103
`define DRT_A_ACC1_L 16'h1104
`define DRT_A_DEC1_H 16'h1105
`define DRT_A_DEC1_L 16'h1106
`define DRT_A_ACC2_H 16'h2103
`define DRT_A_ACC2_L 16'h2104
`define DRT_A_DEC2_H 16'h2105
`define DRT_A_DEC2_L 16'h2106
`define DRT_A_ACC3_H 16'h3103
`define DRT_A_ACC3_L 16'h3104
`define DRT_A_DEC3_H 16'h3105
`define DRT_A_DEC3_L 16'h3106

// Trip word and interrupt registers.
`define DRT_A_TRIP 16'h0f00
`define DRT_A_IRQ_STS 16'h0f01
`define DRT_A_IRQ_CLR 16'h0f02
`define DRT_A_IRQ_EN 16'h0f03

// Interrupt status bit positions.
`define DRT_B_TRIP 0
`define DRT_B_RANGE 1

// Trip cause codes carried in the high byte of the trip word.
`define DRT_C_NONE 8'h00
`define DRT_C_OC_CONST 8'h01
`define DRT_C_OC_DECEL 8'h02
`define DRT_C_OC_ACCEL 8'h03
`define DRT_C_OC_OTHER 8'h04
`define DRT_C_PROT_BASE 8'h05
`define DRT_N_PROT 4'hc
`define DRT_C_THERM_FAN 8'h14
`define DRT_C_THERM 8'h15
`define DRT_C_HW0 8'h17
`define DRT_C_HW1 8'h18
`define DRT_C_HW2 8'h19
`define DRT_C_HW3 8'h1e
`define DRT_C_HW4 8'h23
`define DRT_C_HW5 8'h24
`define DRT_C_HW6 8'h25
`define DRT_C_HW7 8'h26
`define DRT_C_SEQ_INSTR 8'h2b
`define DRT_C_SEQ_NEST 8'h2c
`define DRT_C_SEQ_EXEC 8'h2d
`define DRT_C_SEQ_USER 8'h32
`define DRT_C_CARD1 8'h3c
`define DRT_C_CARD2 8'h46
`define DRT_N_SUB 4'ha
`define DRT_N_HW 4'h8
`define DRT_STAT_MAX 4'h9

// Value limits in 0.01 Hz and 0.01 s units.
`define DRT_FREQ_MAX 32'h0000_9c40
`define DRT_TIME_MIN 32'h0000_0001
`define DRT_TIME_MAX 32'h0005_7e40
`define DRT_TRUNC_AT 19'h2710
`define DRT_TEN 19'h000a
`define DRT_NET_SEL 8'h03

// Reset values of the parameters.
`define DRT_FREQ_RST 16'h0000
`define DRT_TIME_RST 19'h0bb8
`define DRT_N_WORDS 14

`endif

// File: verilog/drt_pkg.sv
package drt_pkg;

   // Fault class reported by the protection logic with a trip.
   typedef enum logic [3:0] {
      DRT_TC_NONE,
      DRT_TC_OC_CONST,
      DRT_TC_OC_DECEL,
      DRT_TC_OC_ACCEL,
      DRT_TC_OC_OTHER,
      DRT_TC_PROTECT,
      DRT_TC_THERM_FAN,
      DRT_TC_THERM,
      DRT_TC_HW,
      DRT_TC_SEQ_INSTR,
      DRT_TC_SEQ_NEST,
      DRT_TC_SEQ_EXEC,
      DRT_TC_SEQ_USER,
      DRT_TC_CARD1,
      DRT_TC_CARD2
   } drt_trip_e;

   // Whole state of the register bank.
   typedef struct packed {
      logic [6:0][15:0] hi;
      logic [15:0] freq;
      logic [2:0][18:0] acc;
      logic [2:0][18:0] dec;
      logic [7:0] cause;
      logic [7:0] dstat;
      logic [1:0] sts;
      logic [1:0] ien;
      logic [15:0] rdata;
      logic net;
      logic [18:0] acc_out;
      logic [18:0] dec_out;
      logic irq;
   } drt_state_s;

   // State of the parameter word store.
   typedef struct packed {
      logic [13:0][15:0] word;
      logic [15:0] rdata;
   } drt_mem_s;

endpackage : drt_pkg

// File: verilog/drt_pmem.sv
`timescale 1ns/100ps
`include "drt_cfg.svh"

module drt_pmem (
   input wire logic clk_i,
   input wire logic nrst_i,
   drt_pmem_if.mem pm
);

   drt_pkg::drt_mem_s s;
   drt_pkg::drt_mem_s next_s;

   // Each word takes a write when addressed; read data are zero outside a read cycle,
   // so the bank can merge them with its own read data by a plain OR.
   generate
      for (genvar i = 0; i < `DRT_N_WORDS; i++) begin : g_word
         always_comb begin
            next_s.word[i] = s.word[i];
            if (pm.we && pm.waddr == 4'(i)) begin
               next_s.word[i] = pm.wdata;
            end
         end
      end
   endgenerate

   // Registered read port.
   always_comb begin
      next_s.rdata = 16'h0000;
      if (pm.re && pm.raddr < 4'(`DRT_N_WORDS)) begin
         next_s.rdata = s.word[pm.raddr];
      end
   end

   // Odd words are low halves; time pairs start at their default.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
         for (int k = 3; k < `DRT_N_WORDS; k += 2) begin
            s.word[k] <= 16'(`DRT_TIME_RST);
         end
         s.word[1] <= `DRT_FREQ_RST;
      end else begin
         s <= next_s;
      end
   end

   assign pm.rdata = s.rdata;

endmodule : drt_pmem

// File: verilog/drt_pmem_if.sv
`timescale 1ns/100ps

// Carries word writes and reads between the bank logic and the word store.
interface drt_pmem_if;
   logic we;
   logic re;
   logic [3:0] waddr;
   logic [3:0] raddr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctl (output we, output re, output waddr, output raddr, output wdata, input rdata);
   modport mem (input we, input re, input waddr, input raddr, input wdata, output rdata);
endinterface : drt_pmem_if

// File: verilog/drt_regbank.sv
`timescale 1ns/100ps
`include "drt_cfg.svh"

// Operation
// RULE_01: Trip cause 0 means no trip; 1 to 4 are the overcurrent cases.
// RULE_02: Protection trips use codes 5 to 16, 20, 21 and 23 to 38.
// RULE_03: Sequence faults give 43, 44, 45; user trips 0-9 give 50-59.
// RULE_04: Card one errors give 60 to 69, card two errors 70 to 79.
// RULE_05: Low byte of trip word holds drive status 0 to 9 at trip.
// RULE_06: Frequency target 0 to 40000 steers speed when source select is 03.
// RULE_07: Time values of 10000 or more drop their hundredths digit.
// RULE_08: Parameters are 32-bit high/low pairs; times range 1 to 360000.

module drt_regbank (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire drt_pkg::drt_trip_e trip_class_i,
   input wire logic [3:0] trip_index_i,
   input wire logic [3:0] drive_status_i,
   input wire logic trip_valid_i,
   input wire logic [7:0] freq_src_sel_i,
   input wire logic [1:0] motor_sel_i,
   output logic [15:0] freq_target_o,
   output logic freq_from_net_o,
   output logic [18:0] accel_time_o,
   output logic [18:0] decel_time_o,
   output logic [15:0] trip_word_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Maps a bus address onto a word slot; slot bit 0 marks the low half.
   function automatic logic [4:0] slot_of(input logic [15:0] a);
      case (a)
         `DRT_A_FREQ_H: slot_of = 5'h10;
         `DRT_A_FREQ_L: slot_of = 5'h11;
         `DRT_A_ACC1_H: slot_of = 5'h12;
         `DRT_A_ACC1_L: slot_of = 5'h13;
         `DRT_A_DEC1_H: slot_of = 5'h14;
         `DRT_A_DEC1_L: slot_of = 5'h15;
         `DRT_A_ACC2_H: slot_of = 5'h16;
         `DRT_A_ACC2_L: slot_of = 5'h17;
         `DRT_A_DEC2_H: slot_of = 5'h18;
         `DRT_A_DEC2_L: slot_of = 5'h19;
         `DRT_A_ACC3_H: slot_of = 5'h1a;
         `DRT_A_ACC3_L: slot_of = 5'h1b;
         `DRT_A_DEC3_H: slot_of = 5'h1c;
         `DRT_A_DEC3_L: slot_of = 5'h1d;
         default: slot_of = 5'h00;
      endcase
   endfunction : slot_of

   // Once a time reaches 100.0 s the hundredths digit is dropped.
   function automatic logic [18:0] trunc_time(input logic [18:0] v);
      if (v >= `DRT_TRUNC_AT) begin // see RULE_07
         trunc_time = v - (v % `DRT_TEN);
      end else begin
         trunc_time = v;
      end
   endfunction : trunc_time

   // Encodes a fault class and sub-index into a cause code; bit 8 flags a legal pair.
   function automatic logic [8:0] trip_code(input drt_pkg::drt_trip_e c, input logic [3:0] i);
      logic [7:0] hw;
      hw = `DRT_C_HW0;
      case (i[2:0])
         3'h1: hw = `DRT_C_HW1;
         3'h2: hw = `DRT_C_HW2;
         3'h3: hw = `DRT_C_HW3;
         3'h4: hw = `DRT_C_HW4;
         3'h5: hw = `DRT_C_HW5;
         3'h6: hw = `DRT_C_HW6;
         3'h7: hw = `DRT_C_HW7;
         default: hw = `DRT_C_HW0;
      endcase
      case (c)
         drt_pkg::DRT_TC_NONE: trip_code = {1'b1, `DRT_C_NONE}; // see RULE_01
         drt_pkg::DRT_TC_OC_CONST: trip_code = {1'b1, `DRT_C_OC_CONST}; // see RULE_01
         drt_pkg::DRT_TC_OC_DECEL: trip_code = {1'b1, `DRT_C_OC_DECEL};
         drt_pkg::DRT_TC_OC_ACCEL: trip_code = {1'b1, `DRT_C_OC_ACCEL};
         drt_pkg::DRT_TC_OC_OTHER: trip_code = {1'b1, `DRT_C_OC_OTHER};
         drt_pkg::DRT_TC_PROTECT: trip_code = {i < `DRT_N_PROT, `DRT_C_PROT_BASE + {4'h0, i}}; // see RULE_02
         drt_pkg::DRT_TC_THERM_FAN: trip_code = {1'b1, `DRT_C_THERM_FAN}; // see RULE_02
         drt_pkg::DRT_TC_THERM: trip_code = {1'b1, `DRT_C_THERM};
         drt_pkg::DRT_TC_HW: trip_code = {i < `DRT_N_HW, hw}; // see RULE_02
         drt_pkg::DRT_TC_SEQ_INSTR: trip_code = {1'b1, `DRT_C_SEQ_INSTR}; // see RULE_03
         drt_pkg::DRT_TC_SEQ_NEST: trip_code = {1'b1, `DRT_C_SEQ_NEST};
         drt_pkg::DRT_TC_SEQ_EXEC: trip_code = {1'b1, `DRT_C_SEQ_EXEC};
         drt_pkg::DRT_TC_SEQ_USER: trip_code = {i < `DRT_N_SUB, `DRT_C_SEQ_USER + {4'h0, i}}; // see RULE_03
         drt_pkg::DRT_TC_CARD1: trip_code = {i < `DRT_N_SUB, `DRT_C_CARD1 + {4'h0, i}}; // see RULE_04
         drt_pkg::DRT_TC_CARD2: trip_code = {i < `DRT_N_SUB, `DRT_C_CARD2 + {4'h0, i}}; // see RULE_04
         default: trip_code = {1'b0, `DRT_C_NONE};
      endcase
   endfunction : trip_code

   ////////////////////////////////////////////////////////////////////////////////
   // State and decode.

   drt_pkg::drt_state_s s;
   drt_pkg::drt_state_s next_s;
   drt_pmem_if pm ();

   logic [4:0] slot;
   logic [2:0] pair;
   logic [31:0] joined;
   logic [8:0] tcode;
   logic trip_take;
   logic in_range;
   logic [1:0] set_ev;
   logic [1:0] clr_ev;
   logic [1:0] mot;

   assign slot = slot_of(addr_i);
   assign pair = slot[3:1];
   assign joined = {s.hi[pair], wdata_i};
   assign tcode = trip_code(trip_class_i, trip_index_i);
   // A trip with an unknown sub-index or status is dropped rather than half-recorded.
   assign trip_take = trip_valid_i && tcode[8] && drive_status_i <= `DRT_STAT_MAX;
   assign mot = 2'((pair - 3'h1) >> 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   // One pass computes every next value; the word store sees the same decode.
   always_comb begin
      next_s = s;
      next_s.rdata = 16'h0000;
      pm.we = 1'b0;
      pm.re = rd_i && slot[4];
      pm.waddr = slot[3:0];
      pm.raddr = slot[3:0];
      pm.wdata = wdata_i;
      set_ev = 2'b00;
      clr_ev = 2'b00;
      in_range = 1'b0;
      // Pair writes: the high half is staged, the low half commits the whole value.
      if (wr_i && slot[4]) begin
         if (!slot[0]) begin
            next_s.hi[pair] = wdata_i; // see RULE_08
            pm.we = 1'b1;
         end else if (pair == 3'h0) begin
            in_range = joined <= `DRT_FREQ_MAX; // see RULE_06
            if (in_range) begin
               next_s.freq = wdata_i;
            end
         end else begin
            in_range = joined >= `DRT_TIME_MIN && joined <= `DRT_TIME_MAX; // see RULE_08
            if (in_range && pair[0]) begin
               next_s.acc[mot] = trunc_time(joined[18:0]); // see RULE_07
            end else if (in_range) begin
               next_s.dec[mot] = trunc_time(joined[18:0]); // see RULE_07
            end
         end
         // A rejected low half leaves the stored word untouched and raises an event.
         if (slot[0]) begin
            pm.we = in_range;
            set_ev[`DRT_B_RANGE] = !in_range;
         end
      end
      // Local register writes.
      if (wr_i && addr_i == `DRT_A_IRQ_CLR) begin
         clr_ev = wdata_i[1:0];
      end
      if (wr_i && addr_i == `DRT_A_IRQ_EN) begin
         next_s.ien = wdata_i[1:0];
      end
      // Trip capture: cause in the high byte, drive status in the low byte.
      if (trip_take) begin
         next_s.cause = tcode[7:0]; // see RULE_01
         next_s.dstat = {4'h0, drive_status_i}; // see RULE_05
         set_ev[`DRT_B_TRIP] = trip_class_i != drt_pkg::DRT_TC_NONE;
      end
      // A set in the same cycle as its clear wins, so no event is lost.
      next_s.sts = (s.sts & ~clr_ev) | set_ev;
      next_s.irq = |(next_s.sts & next_s.ien);
      // Local read data; the store answers its own words.
      if (rd_i) begin
         case (addr_i)
            `DRT_A_TRIP: next_s.rdata = {s.cause, s.dstat};
            `DRT_A_IRQ_STS: next_s.rdata = {14'h0000, s.sts};
            `DRT_A_IRQ_EN: next_s.rdata = {14'h0000, s.ien};
            default: next_s.rdata = 16'h0000;
         endcase
      end
      // The network target steers speed only under the matching source selection.
      next_s.net = freq_src_sel_i == `DRT_NET_SEL; // see RULE_06
      next_s.acc_out = s.acc[motor_sel_i < 2'h3 ? motor_sel_i : 2'h0];
      next_s.dec_out = s.dec[motor_sel_i < 2'h3 ? motor_sel_i : 2'h0];
   end

   // State register.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
         s.freq <= `DRT_FREQ_RST;
         s.acc <= {3{`DRT_TIME_RST}};
         s.dec <= {3{`DRT_TIME_RST}};
         s.acc_out <= `DRT_TIME_RST;
         s.dec_out <= `DRT_TIME_RST;
      end else begin
         s <= next_s;
      end
   end

   drt_pmem u_pmem (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .pm(pm.mem)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Both read sources are zero outside their read cycle, so an OR merges them.
   assign rdata_o = s.rdata | pm.rdata;
   assign freq_target_o = s.freq;
   assign freq_from_net_o = s.net;
   assign accel_time_o = s.acc_out;
   assign decel_time_o = s.dec_out;
   assign trip_word_o = {s.cause, s.dstat};
   assign irq_o = s.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence acc1_hi_zero;
      wr_i && addr_i == `DRT_A_ACC1_H && wdata_i == 16'h0000;
   endsequence

   sequence acc1_lo_small;
      wr_i && addr_i == `DRT_A_ACC1_L && s.hi[1] == 16'h0000
         && wdata_i >= 16'h0001 && wdata_i < 16'h2710;
   endsequence

   sequence freq_lo_bad;
      wr_i && addr_i == `DRT_A_FREQ_L && {s.hi[0], wdata_i} > `DRT_FREQ_MAX;
   endsequence

   // A report with a status above 9 or a card-one index above 9 must leave the whole trip word as it was.
   sequence trip_refused;
      trip_valid_i && (drive_status_i > 4'h9
         || (trip_class_i == drt_pkg::DRT_TC_CARD1 && trip_index_i > 4'h9));
   endsequence

   // Either end of the time range is refused on the low-half write.
   sequence acc1_lo_bad;
      wr_i && addr_i == `DRT_A_ACC1_L
         && ({s.hi[1], wdata_i} < `DRT_TIME_MIN || {s.hi[1], wdata_i} > `DRT_TIME_MAX);
   endsequence

   no_trip_a: assert property ( // see RULE_01
      trip_valid_i && trip_class_i == drt_pkg::DRT_TC_NONE && drive_status_i == 4'h1
      |=> trip_word_o == 16'h0001)
      else $error("no-trip report did not clear the cause");

   oc_accel_a: assert property ( // see RULE_01
      trip_take && trip_class_i == drt_pkg::DRT_TC_OC_ACCEL |=> trip_word_o[15:8] == 8'h03)
      else $error("overcurrent during acceleration not coded 3");

   thermal_code_a: assert property ( // see RULE_02
      trip_take && trip_class_i == drt_pkg::DRT_TC_THERM_FAN |=> trip_word_o[15:8] == 8'h14)
      else $error("low-fan thermal trip not coded 20");

   seq_user_a: assert property ( // see RULE_03
      trip_take && trip_class_i == drt_pkg::DRT_TC_SEQ_USER
      |=> trip_word_o[15:8] == 8'h32 + {4'h0, $past(trip_index_i)})
      else $error("sequence user trip code wrong");

   card_two_a: assert property ( // see RULE_04
      trip_take && trip_class_i == drt_pkg::DRT_TC_CARD2
      |=> trip_word_o[15:8] == 8'h46 + {4'h0, $past(trip_index_i)} && (irq_o || !s.ien[0]))
      else $error("card two error code wrong");

   trip_status_a: assert property ( // see RULE_05
      trip_take |=> trip_word_o[7:0] == {4'h0, $past(drive_status_i)})
      else $error("drive status not captured at the trip");

   // Read data stand only in the cycle after the strobe, so compare there.
   trip_read_a: assert property ( // see RULE_05
      rd_i && addr_i == `DRT_A_TRIP |=> rdata_o == $past(trip_word_o))
      else $error("trip word not read back");

   protect_code_a: assert property ( // see RULE_02
      trip_take && trip_class_i == drt_pkg::DRT_TC_PROTECT
      |=> trip_word_o[15:8] == 8'h05 + {4'h0, $past(trip_index_i)})
      else $error("protection trip code wrong");

   thermal_plain_a: assert property ( // see RULE_02
      trip_take && trip_class_i == drt_pkg::DRT_TC_THERM |=> trip_word_o[15:8] == 8'h15)
      else $error("plain thermal trip not coded 21");

   seq_exec_a: assert property ( // see RULE_03
      trip_take && trip_class_i == drt_pkg::DRT_TC_SEQ_EXEC |=> trip_word_o[15:8] == 8'h2d)
      else $error("sequence execution error not coded 45");

   card_one_a: assert property ( // see RULE_04
      trip_take && trip_class_i == drt_pkg::DRT_TC_CARD1
      |=> trip_word_o[15:8] == 8'h3c + {4'h0, $past(trip_index_i)})
      else $error("card one error code wrong");

   trip_drop_a: assert property ( // see RULE_05
      trip_refused |=> $stable(trip_word_o))
      else $error("refused trip report changed the trip word");

   freq_reject_a: assert property ( // see RULE_06
      freq_lo_bad |=> $stable(freq_target_o) && s.sts[`DRT_B_RANGE])
      else $error("out-of-range frequency accepted");

   net_select_a: assert property ( // see RULE_06
      freq_src_sel_i == 8'h03 |=> freq_from_net_o)
      else $error("network target not selected under source 03");

   trunc_time_a: assert property ( // see RULE_07
      s.acc[0] >= 19'h2710 |-> s.acc[0] % 19'h000a == 19'h0000)
      else $error("hundredths digit kept above 100.0 s");

   freq_accept_a: assert property ( // see RULE_06
      wr_i && addr_i == `DRT_A_FREQ_L && {s.hi[0], wdata_i} <= `DRT_FREQ_MAX
      |=> freq_target_o == $past(wdata_i))
      else $error("legal frequency target not taken");

   time_reject_a: assert property ( // see RULE_08
      acc1_lo_bad |=> $stable(s.acc[0]) && s.sts[`DRT_B_RANGE])
      else $error("out-of-range acceleration time accepted");

   // The master may leave one idle cycle between the two halves of a pair.
   pair_commit_a: assert property ( // see RULE_08
      acc1_hi_zero ##[1:2] acc1_lo_small |=> s.acc[0] == {3'h0, $past(wdata_i)})
      else $error("acceleration pair did not commit");

endmodule : drt_regbank
